// file: mesc_pkg.sv
`default_nettype none
package mesc_pkg;
    // Timing figures
    localparam int CLK_PERIOD_NS   = 20;
    localparam int EXT_RST_DLY_NS  = 10000;
    localparam int EXT_RST_MIN_NS  = 4000;
    localparam int POR_HOLD_NS     = 10000;
    localparam int PASS_MAX_MS     = 100;
    localparam int EXT_RST_DLY_CYC = EXT_RST_DLY_NS / CLK_PERIOD_NS;
    localparam int EXT_RST_MIN_CYC = (EXT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_HOLD_CYC    = POR_HOLD_NS / CLK_PERIOD_NS;
    localparam int PASS_MAX_CYC    = PASS_MAX_MS * 1000000 / CLK_PERIOD_NS;

    // Register offsets
    localparam logic [7:0] OFS_CFG      = 8'h00;
    localparam logic [7:0] OFS_SLEEP    = 8'h01;
    localparam logic [7:0] OFS_SELECT   = 8'h02;
    localparam logic [7:0] OFS_GPI_MSK  = 8'h03;
    localparam logic [7:0] OFS_MISC_MSK = 8'h04;
    localparam logic [7:0] OFS_S1_GPI   = 8'h05;
    localparam logic [7:0] OFS_S3_GPI   = 8'h06;
    localparam logic [7:0] OFS_S3_TV    = 8'h07;
    localparam logic [7:0] OFS_S45_GPI  = 8'h08;
    localparam logic [7:0] OFS_S45_TV   = 8'h09;
    localparam logic [7:0] OFS_USR_LIM  = 8'h0A;
    localparam logic [7:0] OFS_GPI_RAW  = 8'h0B;
    localparam logic [7:0] OFS_VLIM     = 8'h10;
    localparam logic [7:0] OFS_TLIM     = 8'h20;
    localparam logic [7:0] OFS_TACHLIM  = 8'h24;
    localparam logic [7:0] OFS_MGMT_ST  = 8'h30;
    localparam logic [7:0] OFS_HOST_ST  = 8'h38;
    localparam logic [7:0] OFS_VALUE    = 8'h40;

    // Configuration fields
    localparam int CFG_LOCK  = 0;
    localparam int CFG_ALERT = 1;
    localparam int CFG_GLOBAL_EVENT_MASK_BIT  = 2;
    localparam int CFG_ASF   = 3;

    // Reset values
    localparam logic [7:0] CFG_RST      = 8'h04;
    localparam logic [7:0] VLIM_RST     = 8'hFF;
    localparam logic [7:0] TLIM_RST     = 8'h80;
    localparam logic [7:0] TACHLIM_RST  = 8'hFF;
    localparam logic [7:0] USRLIM_RST   = 8'hFF;
    localparam logic [7:0] GPI_MSK_RST  = 8'hFF;
    localparam logic [7:0] MISC_MSK_RST = 8'h3F;
    localparam logic [7:0] TV_MSK_RST   = 8'h07;
    localparam logic [7:0] SELECT_RST   = 8'h0F;

    // Sleep states
    localparam logic [1:0] SLP_S0  = 2'h0;
    localparam logic [1:0] SLP_S1  = 2'h1;
    localparam logic [1:0] SLP_S3  = 2'h2;
    localparam logic [1:0] SLP_S45 = 2'h3;

    // Event vector layout
    localparam int EV_VOLT = 0;
    localparam int EV_TEMP = 16;
    localparam int EV_DIOD = 20;
    localparam int EV_TACH = 24;
    localparam int EV_GPI  = 28;
    localparam int EV_VRD  = 36;
    localparam int EV_USR  = 38;
    localparam int EV_PRED = 39;
    localparam int EV_W    = 48;
    localparam int ST_BYTES = 6;
    localparam int NCH     = 21;

    // Slave addresses from the strap
    localparam logic [6:0] SA_LOW  = 7'h2C;
    localparam logic [6:0] SA_MID  = 7'h2E;
    localparam logic [6:0] SA_HIGH = 7'h2D;

    typedef enum logic [2:0] {
        SQ_ISSUE = 3'b001,
        SQ_BUSY  = 3'b010,
        SQ_HOLD  = 3'b100
    } mesc_seq_t;
endpackage
`default_nettype wire

// file: mesc_top.sv
`timescale 1ns/1ps
`default_nettype none
module mesc_top
    import mesc_pkg::*;
#(
    parameter int PASS_CYC = PASS_MAX_CYC
) (
    // Clock and power-on reset
    input  wire logic       CLK,
    input  wire logic       RSTN,
    // Register port
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output var  logic [7:0] RDATA,
    // Open-drain reset pin
    input  wire logic       RESET_PIN_I,
    output var  logic       RESET_PIN_O,
    output var  logic       RESET_PIN_OE,
    // Bus address strap and first transaction marker
    input  wire logic [1:0] ADDR_SEL_LVL,
    input  wire logic       BUS_START,
    output var  logic [6:0] SLAVE_ADDR,
    output var  logic       SLAVE_ADDR_VALID,
    // Error events from the measurement side
    input  wire logic [15:0] VOLT_ERR,
    input  wire logic [3:0]  TEMP_ERR,
    input  wire logic [3:0]  DIODE_ERR,
    input  wire logic [3:0]  TACH_ERR,
    input  wire logic        USER_THR_ERR,
    input  wire logic [1:0]  PRED_THR_ERR,
    // Pins from the board
    input  wire logic [7:0]  GENERAL_INPUT,
    input  wire logic [1:0]  REGULATOR_HOT_INPUT,
    // Converter handshake
    output var  logic        CONV_START,
    output var  logic [4:0]  CONV_CH,
    input  wire logic        CONV_DONE,
    input  wire logic [7:0]  CONV_DATA,
    // Error outputs
    output var  logic        MGMT_ERROR_OUT,
    output var  logic        HOST_ERROR_OUT,
    output var  logic        ALERT_N
);

    logic [7:0]      cfg_r, sleep_mask_sel_r, select_r, gpi_msk_r, misc_msk_r;
    logic [1:0]      sleep_r;
    logic [7:0]      s1_gpi_r, s3_gpi_r, s3_tv_r, s45_gpi_r, s45_tv_r, usr_lim_r;
    logic [7:0]      vlim_r [16];
    logic [7:0]      tlim_r [4];
    logic [7:0]      tachlim_r [4];
    logic [7:0]      val_r [NCH];
    logic [EV_W-1:0] mst_r, hst_r, ev, msk, mclr, hclr;
    logic [9:0]      pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
    logic [2:0]      rst_s_r;
    logic            rst_f_r, ext_pend_r, ext_fire;
    logic [15:0]     ext_cnt_r, por_cnt_r;
    logic [1:0]      sel_s1_r, sel_s2_r, sel_s3_r, sel_f_r;
    mesc_seq_t       seq_r;
    logic [31:0]     pass_cnt_r;
    logic [4:0]      nxt_ch;
    logic            wr_ok;

    // Pins outside the clock domain: a change counts once stages two and three agree
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            pin_f_r  <= '0;
            rst_s_r  <= 3'h7;
            rst_f_r  <= 1'b1;
            sel_s1_r <= '0;
            sel_s2_r <= '0;
            sel_s3_r <= '0;
            sel_f_r  <= '0;
        end else begin
            pin_s1_r <= {REGULATOR_HOT_INPUT, GENERAL_INPUT};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_f_r  <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
            rst_s_r  <= {rst_s_r[1:0], RESET_PIN_I};
            if (rst_s_r[1] == rst_s_r[2]) begin
                rst_f_r <= rst_s_r[2];
            end
            sel_s1_r <= ADDR_SEL_LVL;
            sel_s2_r <= sel_s1_r;
            sel_s3_r <= sel_s2_r;
            if (sel_s2_r == sel_s3_r) begin
                sel_f_r <= sel_s3_r;
            end
        end
    end

    // Drive the reset pin low for a while after power-up, then release it as input
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            por_cnt_r    <= '0;
            RESET_PIN_OE <= 1'b1;
            RESET_PIN_O  <= 1'b0;
        end else begin
            RESET_PIN_O <= 1'b0;
            if (por_cnt_r < 16'(POR_HOLD_CYC)) begin
                por_cnt_r <= por_cnt_r + 16'h0001;
            end else begin
                RESET_PIN_OE <= 1'b0;
            end
        end
    end

    // Pin assertion starts a fixed delay; short pulses still fire it once detected
    // Only a fall of the filtered level with the pin released (RESET_PIN_OE low) counts, so our own power-up drive never fires it
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ext_pend_r <= 1'b0;
            ext_cnt_r  <= '0;
        end else if (ext_pend_r) begin
            ext_cnt_r <= ext_cnt_r + 16'h0001;
            if (ext_fire) begin
                ext_pend_r <= 1'b0;
            end
        end else if (!RESET_PIN_OE && rst_f_r && rst_s_r[2] == rst_s_r[1] && !rst_s_r[2]
                     && ext_cnt_r == 16'h0000) begin
            ext_pend_r <= 1'b1;
            ext_cnt_r  <= 16'h0002;
        end else if (rst_f_r) begin
            ext_cnt_r <= '0; // Rearm once the pin is seen high again
        end
    end
    assign ext_fire = ext_pend_r && ext_cnt_r == 16'(EXT_RST_DLY_CYC);

    // Guarded registers: lock blocks writes to limits and masks
    assign wr_ok = WR && !cfg_r[CFG_LOCK];

    // Configuration and sleep state, the only ones the pin reset reaches
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_r   <= CFG_RST;
            sleep_r <= SLP_S0;
        end else begin
            if (WR && ADDR == OFS_CFG) begin
                cfg_r <= WDATA;
            end
            if (WR && ADDR == OFS_SLEEP) begin
                sleep_r <= WDATA[1:0];
            end
            if (ext_fire) begin
                cfg_r[CFG_LOCK] <= 1'b0;
                sleep_r         <= SLP_S45;
            end
        end
    end

    // Limits and masks, cleared only at power-on
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            select_r  <= SELECT_RST;
            gpi_msk_r <= GPI_MSK_RST;
            misc_msk_r <= MISC_MSK_RST;
            s1_gpi_r  <= GPI_MSK_RST;
            s3_gpi_r  <= GPI_MSK_RST;
            s45_gpi_r <= GPI_MSK_RST;
            s3_tv_r   <= TV_MSK_RST;
            s45_tv_r  <= TV_MSK_RST;
            usr_lim_r <= USRLIM_RST;
            for (int i = 0; i < 16; i++) vlim_r[i] <= VLIM_RST;
            for (int i = 0; i < 4; i++) tlim_r[i] <= TLIM_RST;
            for (int i = 0; i < 4; i++) tachlim_r[i] <= TACHLIM_RST;
        end else if (wr_ok) begin
            if (ADDR == OFS_SELECT) begin
                select_r <= {4'h0, WDATA[3:0]};
            end else if (ADDR == OFS_GPI_MSK) begin
                gpi_msk_r <= WDATA;
            end else if (ADDR == OFS_MISC_MSK) begin
                misc_msk_r <= {2'h0, WDATA[5:0]};
            end else if (ADDR == OFS_S1_GPI) begin
                s1_gpi_r <= WDATA;
            end else if (ADDR == OFS_S3_GPI) begin
                s3_gpi_r <= WDATA;
            end else if (ADDR == OFS_S3_TV) begin
                s3_tv_r <= {4'h0, WDATA[3:0]};
            end else if (ADDR == OFS_S45_GPI) begin
                s45_gpi_r <= WDATA;
            end else if (ADDR == OFS_S45_TV) begin
                s45_tv_r <= {4'h0, WDATA[3:0]};
            end else if (ADDR == OFS_USR_LIM) begin
                usr_lim_r <= WDATA;
            end else if (ADDR[7:4] == OFS_VLIM[7:4]) begin
                vlim_r[ADDR[3:0]] <= WDATA;
            end else if (ADDR[7:2] == OFS_TLIM[7:2]) begin
                tlim_r[ADDR[1:0]] <= WDATA;
            end else if (ADDR[7:2] == OFS_TACHLIM[7:2]) begin
                tachlim_r[ADDR[1:0]] <= WDATA;
            end
        end
    end
    assign sleep_mask_sel_r = (sleep_r == SLP_S1) ? s1_gpi_r :
                              (sleep_r == SLP_S3) ? s3_gpi_r :
                              (sleep_r == SLP_S45) ? s45_gpi_r : 8'h00;

    // Event vector and the mask built from limits, mask registers and sleep state
    always_comb begin
        ev  = '0;
        msk = '0;
        ev[EV_VOLT +: 16] = VOLT_ERR;
        ev[EV_TEMP +: 4]  = TEMP_ERR;
        ev[EV_DIOD +: 4]  = DIODE_ERR;
        ev[EV_TACH +: 4]  = TACH_ERR;
        ev[EV_GPI +: 8]   = pin_f_r[7:0];
        ev[EV_VRD +: 2]   = pin_f_r[9:8];
        ev[EV_USR]        = USER_THR_ERR;
        ev[EV_PRED +: 2]  = PRED_THR_ERR;
        for (int i = 0; i < 16; i++) begin
            msk[EV_VOLT + i] = vlim_r[i] == VLIM_RST || cfg_r[CFG_GLOBAL_EVENT_MASK_BIT];
        end
        for (int i = 0; i < 3; i++) begin
            // Inputs 11 to 13 carry an optional sleep mask
            msk[EV_VOLT + 11 + i] = msk[EV_VOLT + 11 + i]
                | (sleep_r == SLP_S3 && s3_tv_r[i]) | (sleep_r == SLP_S45 && s45_tv_r[i]);
        end
        for (int i = 0; i < 4; i++) begin
            msk[EV_TEMP + i] = tlim_r[i] == TLIM_RST || cfg_r[CFG_GLOBAL_EVENT_MASK_BIT]
                || (sleep_r == SLP_S3 && s3_tv_r[3]) || (sleep_r == SLP_S45 && s45_tv_r[3]);
            msk[EV_DIOD + i] = msk[EV_TEMP + i];
            // Fans are always ignored with the system off
            msk[EV_TACH + i] = tachlim_r[i] == TACHLIM_RST || cfg_r[CFG_GLOBAL_EVENT_MASK_BIT]
                || sleep_r == SLP_S45;
        end
        for (int i = 0; i < 8; i++) begin
            msk[EV_GPI + i] = gpi_msk_r[i] || sleep_mask_sel_r[i] || cfg_r[CFG_GLOBAL_EVENT_MASK_BIT];
        end
        for (int i = 0; i < 2; i++) begin
            msk[EV_VRD + i] = misc_msk_r[i] || cfg_r[CFG_GLOBAL_EVENT_MASK_BIT];
        end
        msk[EV_USR] = usr_lim_r == USRLIM_RST || cfg_r[CFG_GLOBAL_EVENT_MASK_BIT];
        // Predefined throttle bits stay unmasked
        msk[EV_PRED +: 2] = 2'h0;
    end

    // Clear requests: write-one per set, plus read-clear on the management set in ASF mode
    always_comb begin
        mclr = '0;
        hclr = '0;
        for (int b = 0; b < ST_BYTES; b++) begin
            if (WR && ADDR == OFS_MGMT_ST + 8'(b)) begin
                mclr[8*b +: 8] = WDATA;
            end
            if (RD && cfg_r[CFG_ASF] && ADDR == OFS_MGMT_ST + 8'(b)) begin
                mclr[8*b +: 8] = 8'hFF;
            end
            if (WR && ADDR == OFS_HOST_ST + 8'(b)) begin
                hclr[8*b +: 8] = WDATA;
            end
        end
    end

    // Sticky status sets; a live cause keeps its bit, and a new event beats a clear
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mst_r <= '0;
            hst_r <= '0;
        end else begin
            mst_r <= (mst_r & ~(mclr & ~ev)) | (ev & ~msk);
            hst_r <= (hst_r & ~(hclr & ~ev)) | (ev & ~msk);
        end
    end

    // Error and alert outputs leave the predefined throttle bits out
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            MGMT_ERROR_OUT <= 1'b0;
            HOST_ERROR_OUT <= 1'b0;
            ALERT_N        <= 1'b1;
        end else begin
            MGMT_ERROR_OUT <= |mst_r[EV_PRED-1:0];
            HOST_ERROR_OUT <= |hst_r[EV_PRED-1:0];
            ALERT_N <= !(cfg_r[CFG_ALERT] && |(mst_r[EV_PRED-1:0] | hst_r[EV_PRED-1:0]));
        end
    end

    // Slave address taken once, on the first transaction
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            SLAVE_ADDR       <= SA_LOW;
            SLAVE_ADDR_VALID <= 1'b0;
        end else if (BUS_START && !SLAVE_ADDR_VALID) begin
            SLAVE_ADDR_VALID <= 1'b1;
            SLAVE_ADDR <= (sel_f_r == 2'h0) ? SA_LOW :
                          (sel_f_r == 2'h1) ? SA_MID : SA_HIGH;
        end
    end

    // Next enabled channel in conversion order; wraps to the internal sensor
    always_comb begin
        nxt_ch = CONV_CH + 5'h01;
        if (nxt_ch == 5'd2 && !select_r[0]) nxt_ch = 5'd3;
        if (nxt_ch == 5'd4 && !select_r[1]) nxt_ch = 5'd5;
        if (nxt_ch == 5'd5 && !select_r[2]) nxt_ch = 5'd6;
        if (nxt_ch == 5'd6 && !select_r[3]) nxt_ch = 5'd7;
        if (nxt_ch >= 5'(NCH)) nxt_ch = 5'd0;
    end

    // Round-robin sequencer: one pass per period, started right after power-up
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            seq_r      <= SQ_ISSUE;
            CONV_START <= 1'b0;
            CONV_CH    <= '0;
            pass_cnt_r <= '0;
        end else begin
            CONV_START <= 1'b0;
            pass_cnt_r <= (pass_cnt_r >= 32'(PASS_CYC - 1)) ? 32'h0000_0000
                                                            : pass_cnt_r + 32'h0000_0001;
            case (seq_r)
                SQ_ISSUE: begin
                    CONV_START <= 1'b1;
                    seq_r      <= SQ_BUSY;
                end
                SQ_BUSY: begin
                    if (CONV_DONE) begin
                        CONV_CH <= nxt_ch;
                        seq_r   <= (nxt_ch == 5'd0) ? SQ_HOLD : SQ_ISSUE;
                    end
                end
                SQ_HOLD: begin
                    // Start the next pass on the period boundary
                    if (pass_cnt_r == 32'h0000_0000) begin
                        seq_r <= SQ_ISSUE;
                    end
                end
                default: seq_r <= SQ_ISSUE;
            endcase
        end
    end

    // Value registers hold data only and have no reset
    always_ff @(posedge CLK) begin
        if (seq_r == SQ_BUSY && CONV_DONE) begin
            val_r[CONV_CH] <= CONV_DATA;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= '0;
        end else if (RD) begin
            if (ADDR == OFS_CFG) RDATA <= cfg_r;
            else if (ADDR == OFS_SLEEP) RDATA <= {6'h00, sleep_r};
            else if (ADDR == OFS_SELECT) RDATA <= select_r;
            else if (ADDR == OFS_GPI_MSK) RDATA <= gpi_msk_r;
            else if (ADDR == OFS_MISC_MSK) RDATA <= misc_msk_r;
            else if (ADDR == OFS_S1_GPI) RDATA <= s1_gpi_r;
            else if (ADDR == OFS_S3_GPI) RDATA <= s3_gpi_r;
            else if (ADDR == OFS_S3_TV) RDATA <= s3_tv_r;
            else if (ADDR == OFS_S45_GPI) RDATA <= s45_gpi_r;
            else if (ADDR == OFS_S45_TV) RDATA <= s45_tv_r;
            else if (ADDR == OFS_USR_LIM) RDATA <= usr_lim_r;
            else if (ADDR == OFS_GPI_RAW) RDATA <= pin_f_r[7:0];
            else if (ADDR[7:4] == OFS_VLIM[7:4]) RDATA <= vlim_r[ADDR[3:0]];
            else if (ADDR[7:2] == OFS_TLIM[7:2]) RDATA <= tlim_r[ADDR[1:0]];
            else if (ADDR[7:2] == OFS_TACHLIM[7:2]) RDATA <= tachlim_r[ADDR[1:0]];
            else if (ADDR >= OFS_MGMT_ST && ADDR < OFS_MGMT_ST + 8'(ST_BYTES))
                RDATA <= mst_r[8*(ADDR - OFS_MGMT_ST) +: 8];
            else if (ADDR >= OFS_HOST_ST && ADDR < OFS_HOST_ST + 8'(ST_BYTES))
                RDATA <= hst_r[8*(ADDR - OFS_HOST_ST) +: 8];
            else if (ADDR >= OFS_VALUE && ADDR < OFS_VALUE + 8'(NCH))
                RDATA <= val_r[5'(ADDR - OFS_VALUE)];
            else RDATA <= 8'h00;
        end
    end

    AST_EXT_SLEEP: assert property (@(posedge CLK) disable iff (!RSTN)
        ext_fire |=> sleep_r == SLP_S45 && !cfg_r[CFG_LOCK])
        else $error("Sleep state not forced after pin reset delay");
    AST_EXT_DELAY: assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(ext_pend_r) |-> !ext_fire [*8])
        else $error("Pin reset acted too early");
    AST_STICKY: assert property (@(posedge CLK) disable iff (!RSTN)
        mst_r[0] && !mclr[0] |=> mst_r[0])
        else $error("Management status bit dropped without clear");
    AST_LIVE_KEEP: assert property (@(posedge CLK) disable iff (!RSTN)
        hst_r[EV_TEMP] && ev[EV_TEMP] |=> hst_r[EV_TEMP])
        else $error("Host bit cleared while its cause is active");
    AST_INDEPENDENT: assert property (@(posedge CLK) disable iff (!RSTN)
        hst_r[1] && hclr[1] && !ev[1] && mst_r[1] |=> !hst_r[1] && mst_r[1])
        else $error("Clearing host set disturbed management set");
    AST_MASKED: assert property (@(posedge CLK) disable iff (!RSTN)
        !mst_r[EV_TACH] && msk[EV_TACH] |=> !mst_r[EV_TACH])
        else $error("Masked tach event set a status bit");
    AST_PRED_QUIET: assert property (@(posedge CLK) disable iff (!RSTN)
        mst_r[EV_PRED-1:0] == '0 && hst_r[EV_PRED-1:0] == '0 |=> ALERT_N && !MGMT_ERROR_OUT)
        else $error("Throttle thresholds drove an output");
    AST_ALERT_OFF: assert property (@(posedge CLK) disable iff (!RSTN)
        !cfg_r[CFG_ALERT] |=> ALERT_N)
        else $error("Alert asserted while disabled");
    AST_ASF_RD: assert property (@(posedge CLK) disable iff (!RSTN)
        RD && cfg_r[CFG_ASF] && ADDR == OFS_MGMT_ST && !ev[0] |=> !mst_r[0])
        else $error("Read did not clear management bit in ASF mode");

endmodule // mesc_top
`default_nettype wire

// file: mesc_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module mesc_conv_model (
    // Converter handshake
    input  wire logic       CLK,
    input  wire logic       CONV_START,
    input  wire logic [4:0] CONV_CH,
    output var  logic       CONV_DONE,
    output var  logic [7:0] CONV_DATA
);
    logic [4:0] log_q[$];
    // Odd channels answer slowly; idle data toggles so stale bytes cannot pass
    initial begin
        CONV_DONE = 1'b0;
        CONV_DATA = 8'h00;
        forever begin
            @(posedge CLK);
            CONV_DATA <= ~CONV_DATA;
            if (CONV_START) begin
                log_q.push_back(CONV_CH);
                repeat (CONV_CH[0] ? 5 : 1) @(posedge CLK);
                CONV_DONE <= 1'b1;
                CONV_DATA <= {3'h0, CONV_CH} ^ 8'hA5;
                @(posedge CLK);
                CONV_DONE <= 1'b0;
            end
        end
    end
endmodule // mesc_conv_model
`default_nettype wire

// file: test_mesc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_mesc_top;
    import mesc_pkg::*;
    logic CLK = 0, RSTN = 0, WR = 0, RD = 0, BUS_START = 0, pin_drv = 1, USER_THR_ERR = 0;
    logic [7:0] ADDR = 0, WDATA = 0, RDATA, GENERAL_INPUT = 0, CONV_DATA, d;
    logic [15:0] VOLT_ERR = 0;
    logic [3:0] TEMP_ERR = 0, DIODE_ERR = 0, TACH_ERR = 0;
    logic [1:0] PRED_THR_ERR = 0, REGULATOR_HOT_INPUT = 0, ADDR_SEL_LVL = 2'h1;
    logic [6:0] SLAVE_ADDR;
    logic pin_o, pin_oe, SLAVE_ADDR_VALID, CONV_START, CONV_DONE, MGMT_ERROR_OUT, HOST_ERROR_OUT,
        ALERT_N;
    logic [4:0] CONV_CH;
    int error_cnt = 0, n_tests = 0;
    // Open-drain wire with pull-up
    wire pin_w = pin_drv & ~pin_oe;
    always #10 CLK = ~CLK;
    mesc_top #(.PASS_CYC(2000)) u_mesc_top (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .RESET_PIN_I(pin_w), .RESET_PIN_O(pin_o),
        .RESET_PIN_OE(pin_oe), .ADDR_SEL_LVL(ADDR_SEL_LVL), .BUS_START(BUS_START),
        .SLAVE_ADDR(SLAVE_ADDR), .SLAVE_ADDR_VALID(SLAVE_ADDR_VALID), .VOLT_ERR(VOLT_ERR),
        .TEMP_ERR(TEMP_ERR), .DIODE_ERR(DIODE_ERR), .TACH_ERR(TACH_ERR),
        .USER_THR_ERR(USER_THR_ERR), .PRED_THR_ERR(PRED_THR_ERR),
        .GENERAL_INPUT(GENERAL_INPUT), .REGULATOR_HOT_INPUT(REGULATOR_HOT_INPUT),
        .CONV_START(CONV_START), .CONV_CH(CONV_CH), .CONV_DONE(CONV_DONE),
        .CONV_DATA(CONV_DATA), .MGMT_ERROR_OUT(MGMT_ERROR_OUT), .HOST_ERROR_OUT(HOST_ERROR_OUT),
        .ALERT_N(ALERT_N));
    mesc_conv_model u_mesc_conv_model (.CLK(CLK), .CONV_START(CONV_START), .CONV_CH(CONV_CH),
        .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge CLK);
        WR <= 1; ADDR <= a; WDATA <= v;
        @(posedge CLK);
        WR <= 0;
    endtask
    // Read data is valid from the cycle after the strobe and holds until the next read
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        RD <= 1; ADDR <= a;
        @(posedge CLK);
        RD <= 0;
        #1 d = RDATA;
    endtask
    task automatic t_por;
        rd(OFS_CFG); chk("cfg", 8'h04, d);
        rd(OFS_VLIM); chk("vlim", 8'hFF, d);
        chk("alert", 8'h01, ALERT_N);
        chk("pin_oe", 8'h01, pin_oe);
        chk("pin_o", 8'h00, pin_o);
    endtask
    task automatic t_addr(input logic [6:0] ea);
        @(posedge CLK) BUS_START <= 1;
        @(posedge CLK) BUS_START <= 0;
        #1 chk("saddr", {1'b0, ea}, SLAVE_ADDR);
        chk("svalid", 8'h01, SLAVE_ADDR_VALID);
    endtask
    // Every default-masked source raised together; only predefined throttle may latch
    task automatic t_mask;
        wr(OFS_CFG, 8'h02);
        @(posedge CLK) begin VOLT_ERR <= 16'h0002; TEMP_ERR <= 1; DIODE_ERR <= 1; TACH_ERR <= 1;
            USER_THR_ERR <= 1; GENERAL_INPUT <= 1; REGULATOR_HOT_INPUT <= 1; PRED_THR_ERR <= 1; end
        repeat (10) @(posedge CLK);
        for (int i = 0; i < 4; i++) begin rd(OFS_MGMT_ST + i); chk("mstat", 8'h00, d); end
        rd(OFS_MGMT_ST + 4); chk("mstat4", 8'h80, d);
        chk("alert_pred", 8'h01, ALERT_N);
        chk("merr_pred", 8'h00, MGMT_ERROR_OUT);
        @(posedge CLK) begin VOLT_ERR <= 0; TEMP_ERR <= 0; DIODE_ERR <= 0; TACH_ERR <= 0;
            USER_THR_ERR <= 0; GENERAL_INPUT <= 0; REGULATOR_HOT_INPUT <= 0; PRED_THR_ERR <= 0; end
    endtask
    task automatic t_sticky;
        wr(OFS_VLIM, 8'h7F);
        @(posedge CLK) VOLT_ERR <= 16'h0001;
        wr(OFS_MGMT_ST, 8'h01);
        rd(OFS_MGMT_ST); chk("busy_clr", 8'h01, d);
        @(posedge CLK) VOLT_ERR <= 0;
        repeat (3) @(posedge CLK);
        chk("alert_on", 8'h00, ALERT_N);
        chk("merr_on", 8'h01, MGMT_ERROR_OUT);
        chk("herr_on", 8'h01, HOST_ERROR_OUT);
        rd(OFS_MGMT_ST); chk("sticky", 8'h01, d);
        wr(OFS_MGMT_ST, 8'h01);
        rd(OFS_MGMT_ST); chk("mclr", 8'h00, d);
        chk("merr_clr", 8'h00, MGMT_ERROR_OUT);
        chk("herr_keep", 8'h01, HOST_ERROR_OUT);
        chk("alert_host", 8'h00, ALERT_N);
        rd(OFS_HOST_ST); chk("hkeep", 8'h01, d);
        wr(OFS_HOST_ST, 8'h01);
        repeat (3) @(posedge CLK);
        chk("alert_off", 8'h01, ALERT_N);
    endtask
    // Management set clears on read in that mode; host set keeps its bit
    task automatic t_asf;
        wr(OFS_CFG, 8'h0A);
        @(posedge CLK) VOLT_ERR <= 16'h0001;
        @(posedge CLK) VOLT_ERR <= 0;
        rd(OFS_MGMT_ST); chk("asf_first", 8'h01, d);
        rd(OFS_MGMT_ST); chk("asf_clr", 8'h00, d);
        rd(OFS_HOST_ST); chk("asf_host", 8'h01, d);
        wr(OFS_HOST_ST, 8'h01);
    endtask
    task automatic t_conv;
        for (int i = 0; i < 3000 && u_mesc_conv_model.log_q.size() < NCH; i++) @(posedge CLK);
        for (int i = 0; i < NCH; i++) chk("chan", i, u_mesc_conv_model.log_q[i]);
        rd(OFS_VALUE + 5); chk("value", 8'hA0, d);
    endtask
    task automatic t_pin;
        wr(OFS_CFG, 8'h03);
        wr(OFS_USR_LIM, 8'h12);
        rd(OFS_USR_LIM); chk("locked", 8'hFF, d);
        for (int i = 0; i < 1000 && pin_oe; i++) @(posedge CLK);
        chk("pin_oe_rel", 8'h00, pin_oe);
        // Let the pulled-up pin settle high before the outside party pulls it
        repeat (10) @(posedge CLK);
        @(posedge CLK) pin_drv <= 0;
        repeat (250) @(posedge CLK);
        pin_drv <= 1;
        repeat (400) @(posedge CLK);
        rd(OFS_CFG); chk("lock", 8'h02, d);
        rd(OFS_SLEEP); chk("sleep", {6'h0, SLP_S45}, d);
        rd(OFS_VLIM); chk("vlim_keep", 8'h7F, d);
    endtask
    // Power-on reset in mid-run restores defaults and lets a new strap level count
    task automatic t_rst;
        @(posedge CLK) begin RSTN <= 0; ADDR_SEL_LVL <= 2'h2; end
        repeat (3) @(posedge CLK);
        RSTN <= 1;
        repeat (5) @(posedge CLK);
        t_addr(SA_HIGH);
        rd(OFS_CFG); chk("cfg_por", 8'h04, d);
        rd(OFS_MGMT_ST + 4); chk("mstat4_por", 8'h00, d);
        rd(OFS_VLIM); chk("vlim_por", 8'hFF, d);
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge CLK);
        RSTN <= 1;
        t_por();
        t_addr(SA_MID);
        t_mask();
        t_sticky();
        t_asf();
        t_conv();
        t_pin();
        t_rst();
        complete_run();
    end
    // Watchdog
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end
endmodule // test_mesc_top
`default_nettype wire
